// ===== src/lbm_bypass_mux.sv
// Loop port bypass switch: two cells, retime buffer, cable signal-present flags
//
// Functional notes
// [R1] Skip control high inserts slot; low skips.
// [R2] Cable on cell 0: cell 1 selects paths.
// [R3] Cable on cell 1: cell 0 selects paths.
// [R4] Signal-present high while cable input detected.
// [R5] Present at 400 mV, absent at 100 mV.
// [R6] Board wires cells for retime before/after.
// [R7] Undriven skip control reads high (pull-up).
// [R8] Controller supplies 106.25 or 125 MHz reference; the package lock count assumes a 100 ns core_clk period.
// [R9] Retime locks within 2500 bit times.
// [R10] Path selection combinational on skip controls.
`timescale 1ns/1ns
module lbm_bypass_mux #(
  parameter int unsigned LOCK_CYC = lbm_pkg::LBM_LOCK_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              cable_cell,
  input  wire logic [1:0]        skip_n_drv,
  input  wire logic [1:0]        skip_n_oe,
  input  wire logic [1:0]        env_above_on,
  input  wire logic [1:0]        env_above_off,
  input  wire lbm_pkg::lbm_beat_t ring_in,
  output logic                   ring_in_ready,
  output lbm_pkg::lbm_beat_t     ring_out,
  input  wire logic              ring_out_ready,
  input  wire lbm_pkg::lbm_beat_t slot_in,
  output logic                   slot_in_ready,
  output lbm_pkg::lbm_beat_t     slot_out,
  input  wire logic              slot_out_ready,
  output logic [1:0]             signal_present,
  output logic                   retime_locked,
  output logic                   slot_skipped_mode
);

  // The lock bound check waits up to LOCK_CYC cycles, so the count stays
  // inside the window that a delay range can cover
  if (LOCK_CYC < 1 || LOCK_CYC > 1000) begin : g_bad_lock
    $error("LOCK_CYC out of range");
  end

  // ==========================================================
  // Skip controls
  // [R7] pull-up default
  wire [1:0] skip_n = (skip_n_oe & skip_n_drv) | (~skip_n_oe & lbm_pkg::LBM_PULLUP_LVL);
  // [R1] slot cell control; the cable cell is held inserted by the board
  wire       slot_cell = ~cable_cell;
  wire       inserted  = skip_n[slot_cell];
  assign slot_skipped_mode = ~inserted;

  // ==========================================================
  // Retime buffer: the retiming stage lives in cell 0, so its source is
  // whatever stream enters cell 0 (ring input or slot input)
  wire                 rt_from_ring = (cable_cell == lbm_pkg::LBM_CELL0);
  lbm_pkg::lbm_beat_t  rt_src;
  wire                 rt_in_ready;
  wire                 rt_out_ready;
  lbm_pkg::lbm_beat_t  rt_out;
  assign rt_src = rt_from_ring ? ring_in : slot_in;

  logic [lbm_pkg::LBM_SYM_W-1:0] mem_r [lbm_pkg::LBM_BUF_DEPTH];
  logic                          wr_ptr_r;
  logic                          rd_ptr_r;
  logic [1:0]                    count_r;
  wire                           push = rt_src.valid & rt_in_ready;
  wire                           pop  = rt_out.valid & rt_out_ready;

  assign rt_in_ready  = (count_r != 2'(lbm_pkg::LBM_BUF_DEPTH));
  assign rt_out.valid = (count_r != 2'h0);
  // Storage is never reset, so an empty buffer shows zero rather than stale or unknown data
  assign rt_out.sym   = rt_out.valid ? mem_r[rd_ptr_r] : '0;

  // Buffer storage is not reset; only the pointers and the occupancy count carry control state
  always_ff @(posedge core_clk) begin
    if (push) mem_r[wr_ptr_r] <= rt_src.sym;
  end

  // Pointer and occupancy update
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop)  rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + 2'(push) - 2'(pop);
    end
  end

  // ==========================================================
  // Path selection, purely combinational so a skip change acts at once
  // [R10] no clock in the select path
  // [R2] cable on cell 0: ring input retimed first, then to the slot
  // [R3] cable on cell 1: slot return retimed, ring input passes straight
  always_comb begin
    ring_out      = '0;
    slot_out      = '0;
    ring_in_ready = 1'b0;
    slot_in_ready = 1'b0;
    if (rt_from_ring) begin
      ring_in_ready = rt_in_ready;
      slot_out      = rt_out;
      if (inserted) begin
        ring_out      = slot_in;
        slot_in_ready = ring_out_ready;
      end else begin
        ring_out      = rt_out;
        slot_in_ready = 1'b1;           // Skipped slot traffic is dropped
      end
    end else begin
      slot_in_ready = rt_in_ready;
      slot_out      = ring_in;
      if (inserted) begin
        ring_out      = rt_out;
        ring_in_ready = slot_out_ready;
      end else begin
        ring_out      = ring_in;
        ring_in_ready = ring_out_ready;
      end
    end
  end
  // Skipped slot return is drained so it cannot wedge the buffer
  assign rt_out_ready = rt_from_ring ? (inserted ? slot_out_ready : ring_out_ready)
                                     : (inserted ? ring_out_ready : 1'b1);

  // ==========================================================
  // Envelope comparators come from pins: two flops before use
  logic [1:0] on_meta_r, on_sync_r, off_meta_r, off_sync_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_meta_r  <= 2'h0;
      on_sync_r  <= 2'h0;
      off_meta_r <= 2'h0;
      off_sync_r <= 2'h0;
    end else begin
      on_meta_r  <= env_above_on;
      on_sync_r  <= on_meta_r;
      off_meta_r <= env_above_off;
      off_sync_r <= off_meta_r;
    end
  end

  // [R4] [R5] set above on-threshold, clear below off-threshold, hold between
  logic [1:0] sp_r;
  wire  [1:0] sp_nxt = on_sync_r | (sp_r & off_sync_r);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sp_r <= 2'h0;
    else        sp_r <= sp_nxt;
  end
  assign signal_present = sp_r;

  // ==========================================================
  // Lock timer: counts cycles while the cable cell's signal-present flag is high;
  // loss of the cable envelope forces a relock
  localparam int unsigned LW        = 16;
  localparam int          LOCK_SPAN = int'(LOCK_CYC);   // Bound of the lock check
  logic [LW-1:0] lock_cnt_r;
  logic          locked_r;
  wire           cable_live = sp_r[cable_cell];
  // [R9] lock after LOCK_CYC cycles of signal
  wire           lock_hit   = (lock_cnt_r == LW'(LOCK_CYC - 1));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_r <= '0;
      locked_r   <= 1'b0;
    end else if (!cable_live) begin
      lock_cnt_r <= '0;
      locked_r   <= 1'b0;
    end else if (!locked_r) begin
      lock_cnt_r <= lock_cnt_r + LW'(1);
      locked_r   <= lock_hit;
    end
  end
  assign retime_locked = locked_r;

  // ==========================================================
  // Checks
  a_skip_pullup: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
    (skip_n_oe[slot_cell] == 1'b0) |-> !slot_skipped_mode)
    else $error("undriven skip pin did not insert slot");

  a_insert_mode: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
    slot_skipped_mode == (cable_cell ? (skip_n_oe[0] && !skip_n_drv[0]) : (skip_n_oe[1] && !skip_n_drv[1])))
    else $error("slot mode does not follow skip control");

  a_cell0_bypass: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
    (cable_cell == 1'b0 && !skip_n[1]) |-> (ring_out == slot_out && ring_out == rt_out))
    else $error("cell 1 bypass does not feed ring to both outputs");

  a_cell0_insert: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
    (cable_cell == 1'b0 && skip_n[1]) |-> (ring_out == slot_in && slot_out == rt_out))
    else $error("cell 1 insert path wrong");

  a_cell1_paths: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
    (cable_cell == 1'b1) |-> (slot_out == ring_in && ring_out == (skip_n[0] ? rt_out : ring_in)))
    else $error("cell 0 path selection wrong");

  a_present_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
    $rose(on_sync_r[0]) |=> signal_present[0])
    else $error("signal present not raised");

  a_present_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
    (!on_sync_r[1] && !off_sync_r[1]) |=> !signal_present[1])
    else $error("signal present not cleared below off threshold");

  a_lock_bound: assert property (@(posedge core_clk) disable iff (!rst_n) // [R9]
    (!cable_live ##1 cable_live [*1]) |-> ##[0:LOCK_SPAN] (retime_locked || !cable_live))
    else $error("retime did not lock in time");

  a_mux_instant: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
    // A mode change with no control change in the same cycle means a registered select
    $changed(slot_skipped_mode) |-> ($changed(skip_n_drv) || $changed(skip_n_oe) || $changed(cable_cell)))
    else $error("skip change did not act at once");

  c_locks:    cover property (@(posedge core_clk) disable iff (!rst_n) $rose(retime_locked));
  c_buf_full: cover property (@(posedge core_clk) disable iff (!rst_n) count_r == 2'h2 && rt_src.valid);
  c_skipped:  cover property (@(posedge core_clk) disable iff (!rst_n) slot_skipped_mode && ring_out.valid);
  c_exit_rt:  cover property (@(posedge core_clk) disable iff (!rst_n) cable_cell && !slot_skipped_mode && ring_out.valid);

endmodule

// ===== src/lbm_pkg.sv
// Shared constants and types for the loop port bypass switch
package lbm_pkg;

  // ==========================================================
  // Stream carrier
  localparam int unsigned LBM_SYM_W = 10;           // One line code group per beat

  typedef struct packed {
    logic                 valid;
    logic [LBM_SYM_W-1:0] sym;
  } lbm_beat_t;

  // ==========================================================
  // Cell numbering and pin levels
  localparam logic       LBM_CELL0      = 1'b0;
  localparam logic       LBM_CELL1      = 1'b1;
  localparam logic [1:0] LBM_PULLUP_LVL = 2'h3;     // Undriven skip pins read high

  // ==========================================================
  // Envelope detector thresholds, realised by the analog comparators
  localparam int unsigned LBM_SP_ON_MV  = 400;      // At or above: present
  localparam int unsigned LBM_SP_OFF_MV = 100;      // At or below: absent

  // ==========================================================
  // Retime lock budget
  localparam int unsigned LBM_LOCK_BITS    = 2500;      // Bit times to phase lock
  localparam longint      LBM_LINE_KBPS    = 1062500;   // Slowest line rate
  localparam longint      LBM_CLK_PERIOD_NS = 100;      // core_clk period
  localparam longint      LBM_LOCK_NS      = (longint'(LBM_LOCK_BITS) * 64'd1000000) / LBM_LINE_KBPS;
  localparam int unsigned LBM_LOCK_CYC     = int'(LBM_LOCK_NS / LBM_CLK_PERIOD_NS);  // Longest: rounded down

  // ==========================================================
  // Retime buffer
  localparam int unsigned LBM_BUF_DEPTH = 2;

endpackage

// ===== tb/lbm_drive_model.sv
// Drive transceiver stand-in: stalls on demand, sends a counted stream, logs what it takes
`timescale 1ns/1ns
module lbm_drive_model (
  input  wire logic               core_clk,
  input  wire logic               stall,
  input  wire logic               tx_en,
  input  wire lbm_pkg::lbm_beat_t slot_out,
  output logic                    slot_out_ready,
  output lbm_pkg::lbm_beat_t      slot_in,
  input  wire logic               slot_in_ready
);
  logic [9:0] tx_r = 10'h200;
  logic [9:0] rx_q [$];
  // Idle symbol is the inverse so stale data never looks valid by luck
  assign slot_out_ready = !stall;
  assign slot_in        = '{valid: tx_en, sym: tx_en ? tx_r : ~tx_r};
  // Each symbol holds until the switch takes it
  always @(posedge core_clk) begin
    if (tx_en && slot_in_ready)
      tx_r <= tx_r + 10'h001;
    if (slot_out.valid && slot_out_ready)
      rx_q.push_back(slot_out.sym);
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the loop port bypass switch
`timescale 1ns/1ns
module testbench;
  logic               core_clk, rst_n, cable_cell, ring_out_ready, stall, tx_en;
  logic               ring_in_ready, slot_in_ready, slot_out_ready, retime_locked, slot_skipped_mode;
  logic [1:0]         skip_n_drv, skip_n_oe, env_above_on, env_above_off, signal_present;
  lbm_pkg::lbm_beat_t ring_in, ring_out, slot_in, slot_out;
  int                 num_errors = 0, checks = 0, cyc = 0;
  // Row: cable cell, skip enables, skip levels, expected skipped flag
  logic [5:0]         rows [8] = '{6'h00, 6'h11, 6'h14, 6'h08, 6'h29, 6'h2A, 6'h20, 6'h30};

  lbm_bypass_mux #(.LOCK_CYC(3)) dut (.core_clk(core_clk), .rst_n(rst_n), .cable_cell(cable_cell),
    .skip_n_drv(skip_n_drv), .skip_n_oe(skip_n_oe), .env_above_on(env_above_on),
    .env_above_off(env_above_off), .ring_in(ring_in), .ring_in_ready(ring_in_ready), .ring_out(ring_out),
    .ring_out_ready(ring_out_ready), .slot_in(slot_in), .slot_in_ready(slot_in_ready), .slot_out(slot_out),
    .slot_out_ready(slot_out_ready), .signal_present(signal_present), .retime_locked(retime_locked),
    .slot_skipped_mode(slot_skipped_mode));
  lbm_drive_model far (.core_clk(core_clk), .stall(stall), .tx_en(tx_en), .slot_out(slot_out),
    .slot_out_ready(slot_out_ready), .slot_in(slot_in), .slot_in_ready(slot_in_ready));

  // ==========================================================
  // Clock, hang guard and compare helpers
  // core_clk stands in for the controller's retime reference
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Whole run is about fifty cycles; far past that means a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Edges until a flag reaches its level; sel picks flag and level
  task automatic lat(input int sel, input int exp);
    int n;
    n = 0;
    while (n < 50 && !(sel == 0 ? signal_present[0] === 1'b1 : sel == 1 ? retime_locked === 1'b1 :
                       sel == 2 ? signal_present[0] === 1'b0 : retime_locked === 1'b0)) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(11'(n), 11'(exp));
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, cable_cell, skip_n_drv, skip_n_oe, env_above_on, env_above_off} = '0;
    {ring_out_ready, stall, tx_en} = 3'h4;
    ring_in = '{valid: 1'b0, sym: 10'h155};
    repeat (3) @(negedge core_clk);
    chk({9'h000, signal_present}, 11'h000);
    chk({10'h000, retime_locked}, 11'h000);
    chk({10'h000, slot_out.valid}, 11'h000);
    rst_n = 1'b1;
    // Paths must follow skip controls within the same cycle, no edge needed
    foreach (rows[i]) begin
      @(negedge core_clk);
      {cable_cell, skip_n_oe, skip_n_drv} = rows[i][5:1];
      #1;
      chk({10'h000, slot_skipped_mode}, {10'h000, rows[i][0]});
      if (cable_cell) chk(slot_out, ring_in);
      if (cable_cell && rows[i][0]) chk(ring_out, ring_in);
      if (!cable_cell && !rows[i][0]) chk(ring_out, slot_in);
    end
    $display("mux table done");
    // Board wiring: cable on cell 0, slot inserted; drive and loop stall while two words arrive
    @(negedge core_clk);
    {cable_cell, skip_n_oe, stall, ring_out_ready} = 5'h02;
    ring_in = '{valid: 1'b1, sym: 10'h0A1};
    @(negedge core_clk);
    ring_in.sym = 10'h0A2;
    @(negedge core_clk);
    ring_in.sym = 10'h0A4;                 // Offered while full, so it must be refused
    chk({10'h000, ring_in_ready}, 11'h000);
    chk({10'h000, slot_in_ready}, 11'h000);
    chk(slot_out, {1'b1, 10'h0A1});
    @(negedge core_clk);
    {ring_in.valid, stall, ring_out_ready} = 3'h1;
    repeat (3) @(negedge core_clk);
    chk(11'(far.rx_q.size()), 11'h002);
    chk({1'b0, far.rx_q[0]}, 11'h0A1);
    chk({1'b0, far.rx_q[1]}, 11'h0A2);
    // Slot skipped: one buffered word shows on the ring and on the slot copy
    skip_n_oe = 2'h2;
    ring_in = '{valid: 1'b1, sym: 10'h0A3};
    @(negedge core_clk);
    ring_in.valid = 1'b0;
    chk(ring_out, {1'b1, 10'h0A3});
    chk(slot_out, ring_out);
    chk({10'h000, slot_in_ready}, 11'h001);
    // Cable on cell 1, slot inserted: drive word goes through the buffer to the ring
    {cable_cell, skip_n_oe, tx_en} = 4'h9;
    @(negedge core_clk);
    tx_en = 1'b0;
    chk(ring_out, {1'b1, 10'h200});
    $display("buffer tests done");
    // Envelope flags on both cells, lock count, hysteresis band and loss of signal
    cable_cell = 1'b0;
    {env_above_on, env_above_off} = 4'hF;
    lat(0, 3);
    lat(1, 3);
    @(negedge core_clk);
    env_above_on = 2'h0;
    repeat (5) @(negedge core_clk);
    chk({8'h00, signal_present, retime_locked}, 11'h007);
    env_above_off = 2'h0;
    lat(2, 3);
    lat(3, 1);
    chk({9'h000, signal_present}, 11'h000);
    // Envelope on cell 0 only: cell 1 must stay low
    @(negedge core_clk);
    env_above_on = 2'h1;
    lat(0, 3);
    chk({9'h000, signal_present}, 11'h001);
    // Reset in mid-run clears the flag at once; after release the full sync path applies again
    @(negedge core_clk);
    rst_n = 1'b0;
    #1;
    chk({9'h000, signal_present}, 11'h000);
    chk({10'h000, retime_locked}, 11'h000);
    @(negedge core_clk);
    rst_n = 1'b1;
    lat(0, 3);
    lat(1, 3);
    $display("signal present tests done");
    finish_test();
  end
endmodule
